// ### rnm_pkg.sv
`default_nettype none
package rnm_pkg;
  // ----------------------------------------
  // port count and register indexes
  // ----------------------------------------
  localparam int NUM_PORTS = 4; // ports with their own copy of the map
  localparam int NUM_CFG = 9; // writable words per port
  localparam int REG_STAT = 9; // pseudo id of the queue statistic
  localparam int REG_GRANT = 3; // id of the grant-address word
  localparam int REG_OPTIONS = 8; // id of the options word
  localparam logic [13:0] IDX_QCOUNT = 14'h0837;
  // port 1 word indexes, in id order 0..8
  localparam logic [13:0] CFG_IDX [NUM_CFG] = '{
    14'h1F69, // network identifier
    14'h1F6A, // handshake delay
    14'h1F6B, // response timeout
    14'h1F6C, // grant address
    14'h1F6D, // retry count
    14'h1F7A, // pause time
    14'h1F7B, // messages per pause
    14'h1F7C, // grant interval
    14'h1F7E  // port options
  };
  localparam logic [13:0] PORT_STRIDE = 14'h0020; // words between port copies
  localparam logic [13:0] PAUSE_SKEW = 14'h0001; // pacing group shift on ports 3, 4
  localparam int SKEW_FIRST_PORT = 2; // zero-based port where the shift starts
  localparam int OPT_MASTER_OFF_BIT = 9;
  // ----------------------------------------
  // reset values when factory defaults load
  // ----------------------------------------
  localparam logic [15:0] CFG_DEF [NUM_CFG] = '{
    16'h0000, 16'h0032, 16'h07D0, 16'h0000, 16'h0003,
    16'h05DC, 16'h0004, 16'h0000, 16'h0000
  };
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int TICK_NS = 10_000_000; // one timer unit, 10 ms
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  // ----------------------------------------
  // route values and grant modes
  // ----------------------------------------
  localparam logic [7:0] BC_ALL_EVEN = 8'hFE; // general broadcast
  localparam logic [7:0] BC_ALL_ODD = 8'hFD;
  localparam logic [7:0] BC_DECADE_LO = 8'hE9; // odd value of drops 00-09
  localparam logic [7:0] BC_DECADE_HI = 8'hFC; // even value of drops 90-99
  localparam logic [15:0] GRANT_SPAN = 16'h0064; // 100 values per mode
  localparam logic [15:0] GRANT_MAX = 16'h018F; // 399
  typedef enum logic [1:0] {GM_SINGLE, GM_AUTO, GM_CONT_SINGLE, GM_CONT_AUTO} rnm_gmode_t;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### rnm_grant_engine.sv
`timescale 1ns/100ps
`default_nettype none
module rnm_grant_engine
  import rnm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic master_off,
  input wire logic grant_load,
  input wire logic [15:0] grant_addr,
  input wire logic [15:0] resp_timeout,
  input wire logic [15:0] retries,
  input wire logic [15:0] pause_time,
  input wire logic [15:0] msgs_per_pause,
  input wire logic [15:0] grant_interval,
  input wire logic msg_enq,
  input wire logic link_ack,
  input wire logic reply_done,
  output logic grant_req,
  output logic [6:0] grant_drop,
  output logic msg_send,
  output logic [15:0] queue_count,
  output logic busy
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_GRANT_WAIT, ST_INTERVAL, ST_MSG_WAIT, ST_PAUSE} rnm_est_t;
  typedef struct packed {
    rnm_est_t st;
    rnm_gmode_t gmode;
    logic grant_on; // a grant sequence is live
    logic [6:0] start_drop; // drop written, for the restart
    logic [6:0] drop; // drop of the next grant
    logic [15:0] timer; // counts 10 ms ticks down
    logic [15:0] tries;
    logic [15:0] sent; // messages since last pause
    logic [15:0] qcnt;
    logic greq;
    logic [6:0] gdrop;
    logic msend;
  } rnm_eng_t;
  rnm_eng_t q, n;
  logic done; // current message finished or given up
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    n = q;
    done = 1'b0;
    n.greq = 1'b0;
    n.msend = 1'b0;
    if (tick && q.timer != 16'h0000)
      n.timer = q.timer - 16'h0001;
    case (q.st)
      ST_IDLE:
      begin
        // ordinary traffic goes ahead of the next grant
        if (q.qcnt != 16'h0000)
        begin
          n.msend = 1'b1;
          n.timer = resp_timeout;
          n.tries = 16'h0000;
          n.st = ST_MSG_WAIT;
        end
        else if (q.grant_on)
        begin
          n.greq = 1'b1;
          n.gdrop = q.drop;
          n.timer = resp_timeout;
          n.st = ST_GRANT_WAIT;
        end
      end
      ST_GRANT_WAIT:
      begin
        // a zero timeout still waits one tick
        if (reply_done || (tick && q.timer <= 16'h0001))
        begin
          n.timer = grant_interval;
          n.st = ST_INTERVAL;
          case (q.gmode)
            GM_SINGLE: n.grant_on = 1'b0;
            GM_AUTO:
            begin
              if (q.drop == 7'h00) n.grant_on = 1'b0;
              else n.drop = q.drop - 7'h01;
            end
            GM_CONT_AUTO:
            begin
              if (q.drop == 7'h00) n.drop = q.start_drop;
              else n.drop = q.drop - 7'h01;
            end
            default: n.drop = q.drop; // same drop again
          endcase
        end
      end
      ST_INTERVAL:
      begin
        // queued messages use the gap, then the sequence resumes
        if (q.qcnt != 16'h0000)
        begin
          n.msend = 1'b1;
          n.timer = resp_timeout;
          n.tries = 16'h0000;
          n.st = ST_MSG_WAIT;
        end
        else if (q.timer == 16'h0000)
          n.st = ST_IDLE;
      end
      ST_MSG_WAIT:
      begin
        if (link_ack)
          done = 1'b1;
        else if (tick && q.timer <= 16'h0001)
        begin
          if (q.tries < retries)
          begin
            n.tries = q.tries + 16'h0001;
            n.msend = 1'b1;
            n.timer = resp_timeout;
          end
          else
            done = 1'b1;
        end
        if (done)
        begin
          n.sent = q.sent + 16'h0001;
          n.st = ST_IDLE;
          // pace traffic: a burst of messages, then a pause
          if (msgs_per_pause != 16'h0000 && n.sent >= msgs_per_pause && pause_time != 16'h0000)
          begin
            n.sent = 16'h0000;
            n.timer = pause_time;
            n.st = ST_PAUSE;
          end
        end
      end
      ST_PAUSE:
      begin
        if (q.timer == 16'h0000)
          n.st = ST_IDLE;
      end
      default: n.st = ST_IDLE;
    endcase
    // enqueue and completion in one cycle cancel out below a count of 16'hFFFF
    n.qcnt = q.qcnt + {15'h0000, msg_enq && q.qcnt != 16'hFFFF} - {15'h0000, done};
    if (grant_load && grant_addr <= GRANT_MAX)
    begin
      n.grant_on = 1'b1;
      n.gmode = rnm_gmode_t'(2'(grant_addr / GRANT_SPAN));
      n.start_drop = 7'(grant_addr % GRANT_SPAN);
      n.drop = 7'(grant_addr % GRANT_SPAN);
    end
    // a disabled master stays silent on the network
    if (master_off)
    begin
      n.st = ST_IDLE;
      n.greq = 1'b0;
      n.msend = 1'b0;
    end
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn) q <= '0;
    else q <= n;
  end
  assign grant_req = q.greq;
  assign grant_drop = q.gdrop;
  assign msg_send = q.msend;
  assign queue_count = q.qcnt;
  assign busy = (q.st != ST_IDLE) || q.grant_on;
endmodule // rnm_grant_engine
`default_nettype wire

// ### rnm_master_cfg.sv
// How it works
// - even and odd broadcast values apply alike; only a final 254 forwards
// - partial broadcast selects one drop decade
// - 254 or 253 reaches every drop
// - configuration survives reset unless defaults load
// - options bit 9 disables the master
// - grant address encodes drop and mode
// - response timeout bounds each grant wait
// - resend unacknowledged messages up to retries
// - pause time held in 10 ms units
// - messages sent between pauses is held
// - grant interval spaces automatic grants
// - queued message count is read only
// - automatic mode descends to drop zero
// - continuous automatic restarts from start drop
// - queued messages go out during interval
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module rnm_master_cfg
  import rnm_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  // reset option: load factory defaults instead of keeping values
  input wire logic factory_load,
  // axi4-lite slave
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // slave side route decode
  input wire logic [7:0] route_value,
  input wire logic route_valid,
  input wire logic route_last,
  input wire logic [6:0] own_drop,
  output logic bcast_apply,
  output logic bcast_forward,
  // master side, one lane per port
  input wire logic [PORTS-1:0] msg_enq,
  input wire logic [PORTS-1:0] link_ack,
  input wire logic [PORTS-1:0] reply_done,
  output logic [PORTS-1:0] grant_req,
  output logic [PORTS*7-1:0] grant_drop,
  output logic [PORTS-1:0] msg_send,
  output logic [PORTS-1:0] master_busy
);
  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  // the port field of the decoder is two bits wide
  if (PORTS < 1 || PORTS > 4)
  begin : g_bad_ports
    $error("PORTS must be 1 to 4");
  end
  if (TICK_CYCLES < 1)
  begin : g_bad_tick
    $error("TICK_CYCLES must be at least 1");
  end
  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [PORTS-1:0][NUM_CFG-1:0][15:0] cfg; // per port settings
    logic aw_ok; // write address held
    logic [13:0] aw_idx;
    logic w_ok; // write data held
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic [PORTS-1:0] gload; // grant word was just written
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic bc_apply;
    logic bc_fwd;
  } rnm_cfg_t;
  rnm_cfg_t q, n, rst_val;
  logic [PORTS-1:0][15:0] qcount; // from the engines
  logic [7:0] wr_dec; // decode of the held write index
  logic [7:0] rd_dec; // decode of the read address
  logic [1:0] bc_res;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // index to {hit, read only, port[1:0], id[3:0]}
  function automatic logic [7:0] rnm_decode(input logic [13:0] idx);
    logic [7:0] r;
    logic [13:0] b;
    r = 8'h00;
    for (int p = 0; p < PORTS; p++)
    begin
      b = 14'(p * int'(PORT_STRIDE));
      if (idx == IDX_QCOUNT + b)
        r = {1'b1, 1'b1, 2'(p), 4'(REG_STAT)};
      for (int k = 0; k < NUM_CFG; k++)
      begin
        // the pacing group sits one word higher on the last two ports
        if (idx == CFG_IDX[k] + b + ((p >= SKEW_FIRST_PORT && k >= 5 && k <= 7) ? PAUSE_SKEW : 14'h0000))
          r = {1'b1, 1'b0, 2'(p), 4'(k)};
      end
    end
    return r;
  endfunction
  // route value to {apply here, forward to all ports}
  function automatic logic [1:0] rnm_bcast(input logic [7:0] v, input logic [6:0] drop, input logic last);
    logic hit;
    logic [7:0] dec;
    hit = 1'b0;
    dec = 8'(v - BC_DECADE_LO) >> 1; // pairs share one decade
    if (v == BC_ALL_EVEN || v == BC_ALL_ODD)
      hit = 1'b1;
    else if (v >= BC_DECADE_LO && v <= BC_DECADE_HI)
      hit = (8'(drop / 7'd10) == dec);
    return {hit, last && v == BC_ALL_EVEN};
  endfunction
  // ----------------------------------------
  // reset value
  // ----------------------------------------
  // settings are kept across reset; only factory_load restores them
  always_comb
  begin
    rst_val = '0;
    rst_val.cfg = q.cfg;
    if (factory_load)
    begin
      for (int p = 0; p < PORTS; p++)
        for (int k = 0; k < NUM_CFG; k++)
          rst_val.cfg[p][k] = CFG_DEF[k];
    end
  end
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    n = q;
    n.gload = '0;
    n.bc_apply = 1'b0;
    n.bc_fwd = 1'b0;
    wr_dec = rnm_decode(q.aw_idx);
    rd_dec = rnm_decode(s_axi_araddr[15:2]);
    bc_res = rnm_bcast(route_value, own_drop, route_last);
    // 10 ms time base shared by every port
    n.tick = 1'b0;
    if (q.tick_cnt == TW'(TICK_CYCLES - 1))
    begin
      n.tick_cnt = '0;
      n.tick = 1'b1;
    end
    else
      n.tick_cnt = q.tick_cnt + TW'(1);
    // address and data may come in either order
    if (s_axi_awvalid && !q.aw_ok)
    begin
      n.aw_ok = 1'b1;
      n.aw_idx = s_axi_awaddr[15:2];
    end
    if (s_axi_wvalid && !q.w_ok)
    begin
      n.w_ok = 1'b1;
      n.wdata = s_axi_wdata[15:0];
      n.wstrb = s_axi_wstrb[1:0];
    end
    // perform the write once both halves are held
    if (q.aw_ok && q.w_ok && !q.bvalid)
    begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      if (!wr_dec[7])
        n.bresp = RESP_SLVERR; // unmapped word
      else if (wr_dec[6])
        n.bresp = RESP_SLVERR;
      else
      begin
        if (q.wstrb[0])
          n.cfg[wr_dec[5:4]][wr_dec[3:0]][7:0] = q.wdata[7:0];
        if (q.wstrb[1])
          n.cfg[wr_dec[5:4]][wr_dec[3:0]][15:8] = q.wdata[15:8];
        // arm the grant sequencer with the new word
        if (wr_dec[3:0] == 4'(REG_GRANT))
          n.gload[wr_dec[5:4]] = 1'b1;
      end
    end
    if (q.bvalid && s_axi_bready)
      n.bvalid = 1'b0;
    // read path answers one cycle after the address is taken
    if (s_axi_arvalid && !q.rvalid)
    begin
      n.rvalid = 1'b1;
      n.rdata = 16'h0000;
      n.rresp = RESP_OKAY;
      if (!rd_dec[7])
        n.rresp = RESP_SLVERR;
      else if (rd_dec[6])
        n.rdata = qcount[rd_dec[5:4]];
      else
        n.rdata = q.cfg[rd_dec[5:4]][rd_dec[3:0]];
    end
    else if (q.rvalid && s_axi_rready)
      n.rvalid = 1'b0;
    // broadcast decode is registered into one-cycle apply and forward pulses
    if (route_valid)
    begin
      n.bc_apply = bc_res[1];
      n.bc_fwd = bc_res[0];
    end
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn) q <= rst_val;
    else q <= n;
  end
  // ----------------------------------------
  // bus outputs
  // ----------------------------------------
  assign s_axi_awready = !q.aw_ok;
  assign s_axi_wready = !q.w_ok;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = {16'h0000, q.rdata};
  assign s_axi_rresp = q.rresp;
  assign bcast_apply = q.bc_apply;
  assign bcast_forward = q.bc_fwd;
  // ----------------------------------------
  // one grant engine per port
  // ----------------------------------------
  for (genvar p = 0; p < PORTS; p++)
  begin : g_port
    rnm_grant_engine u_eng (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(q.tick),
      .master_off(q.cfg[p][REG_OPTIONS][OPT_MASTER_OFF_BIT]),
      .grant_load(q.gload[p]),
      .grant_addr(q.cfg[p][REG_GRANT]),
      .resp_timeout(q.cfg[p][2]),
      .retries(q.cfg[p][4]),
      .pause_time(q.cfg[p][5]),
      .msgs_per_pause(q.cfg[p][6]),
      .grant_interval(q.cfg[p][7]),
      .msg_enq(msg_enq[p]),
      .link_ack(link_ack[p]),
      .reply_done(reply_done[p]),
      .grant_req(grant_req[p]),
      .grant_drop(grant_drop[p*7 +: 7]),
      .msg_send(msg_send[p]),
      .queue_count(qcount[p]),
      .busy(master_busy[p])
    );
  end
endmodule // rnm_master_cfg
`default_nettype wire

// ### rnm_cfg_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module rnm_cfg_monitor
  import rnm_pkg::*;
#(
  parameter int PORTS = 1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0] route_value,
  input wire logic route_valid,
  input wire logic route_last,
  input wire logic [6:0] own_drop,
  input wire logic bcast_apply,
  input wire logic bcast_forward,
  input wire logic [PORTS-1:0] grant_req,
  input wire logic [PORTS*7-1:0] grant_drop
);
  // ----------------------------------------
  // helper: own decade matches route value
  // ----------------------------------------
  logic dec_hit; // only meaningful for 233..252
  assign dec_hit = ({1'b0, own_drop} / 8'h0A) == ((route_value - 8'hE9) >> 1);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // bus, route and grant drop checks
  // ----------------------------------------
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  all_bcast_a: assert property (route_valid && route_value inside {8'hFE, 8'hFD} |=> bcast_apply)
    else $error("general broadcast missed");
  decade_bcast_a: assert property (route_valid && route_value >= 8'hE9 && route_value <= 8'hFC
    |=> bcast_apply == $past(dec_hit))
    else $error("partial broadcast decode wrong");
  no_stray_a: assert property (!route_valid |=> !bcast_apply)
    else $error("apply without route element");
  fwd_cause_a: assert property (bcast_forward |-> $past(route_valid && route_last && route_value == 8'hFE))
    else $error("forward without final 254");
  fwd_when_a: assert property (route_valid && route_last && route_value == 8'hFE |=> bcast_forward)
    else $error("final 254 not forwarded");
  drop_range_a: assert property (grant_req[0] |-> grant_drop[6:0] < 7'h64)
    else $error("grant drop out of range");
endmodule // rnm_cfg_monitor
bind rnm_master_cfg rnm_cfg_monitor #(.PORTS(PORTS)) u_mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .route_value(route_value),
  .route_valid(route_valid), .route_last(route_last), .own_drop(own_drop), .bcast_apply(bcast_apply),
  .bcast_forward(bcast_forward), .grant_req(grant_req), .grant_drop(grant_drop));
`default_nettype wire

// ### rnm_net_slave.sv
`timescale 1ns/100ps
`default_nettype none
module rnm_net_slave
#(
  parameter int P = 1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ack_en,
  input wire logic [P-1:0] grant_req,
  input wire logic [P-1:0] msg_send,
  output logic [P-1:0] link_ack,
  output logic [P-1:0] reply_done
);
  // ----------------------------------------
  // far-side slaves, one lane per port
  // ----------------------------------------
  logic [P-1:0] s1_q, s2_q, g1_q, g2_q; // reply latency pipes
  // acks only when enabled, so retries can be provoked
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {s1_q, s2_q, g1_q, g2_q} <= '0;
      link_ack <= '0;
      reply_done <= '0;
    end
    else
    begin
      s1_q <= msg_send;
      s2_q <= s1_q;
      link_ack <= s2_q & {P{ack_en}};
      g1_q <= grant_req;
      g2_q <= g1_q;
      reply_done <= g2_q;
    end
  end
endmodule // rnm_net_slave
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import rnm_pkg::*;
  localparam int P = 4;
  logic aclk = 1'b0, aresetn = 1'b0, fload = 1'b1, ack_en = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bq = 1'b0, arv = 1'b0, rq = 1'b0;
  logic [15:0] awa = 16'h0000, ara = 16'h0000;
  logic [31:0] wd = 32'h00000000;
  logic awr, wrd, bv, arr, rv, bap, bfw;
  logic [1:0] br, rr;
  logic [31:0] rdd;
  logic [7:0] rval = 8'h00;
  logic rvld = 1'b0, rlast = 1'b0;
  logic [6:0] drop = 7'h37; // drop 55, fifties decade
  logic [P-1:0] enq = '0, ack, rdn, greq, msnd, bsy;
  logic [P*7-1:0] gdrop;
  int num_errors = 0, cmp_count = 0, sc = 0;
  int gq[$]; // grant drops seen on port 1
  always #10 aclk = ~aclk;
  rnm_master_cfg #(.PORTS(P), .TICK_CYCLES(8)) dut (.aclk(aclk), .aresetn(aresetn), .factory_load(fload),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bq),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rq), .route_value(rval), .route_valid(rvld), .route_last(rlast),
    .own_drop(drop), .bcast_apply(bap), .bcast_forward(bfw), .msg_enq(enq), .link_ack(ack),
    .reply_done(rdn), .grant_req(greq), .grant_drop(gdrop), .msg_send(msnd), .master_busy(bsy));
  rnm_net_slave #(.P(P)) u_net (.aclk(aclk), .aresetn(aresetn), .ack_en(ack_en), .grant_req(greq),
    .msg_send(msnd), .link_ack(ack), .reply_done(rdn));
  // record grants and sends of port 1, away from the edge that launches them
  always @(negedge aclk)
  begin
    if (greq[0]) gq.push_back(int'(gdrop[6:0]));
    if (msnd[0]) sc++;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // ----------------------------------------
  // bus master: address and data offered together
  // ----------------------------------------
  task wr(input logic [13:0] i, input logic [15:0] d, input logic [1:0] er);
    logic a, w, ta, tw;
    @(posedge aclk);
    awa <= {i, 2'b00};
    wd <= {16'h0000, d};
    {awv, wv, bq} <= 3'h7;
    a = 1'b1;
    w = 1'b1;
    while (a || w)
    begin
      @(negedge aclk);
      ta = a && awr;
      tw = w && wrd;
      @(posedge aclk);
      if (ta) {awv, a} <= 2'h0;
      if (tw) {wv, w} <= 2'h0;
      #1;
    end
    do @(negedge aclk); while (!bv);
    chk("bresp", 32'(er), 32'(br));
    @(posedge aclk);
    bq <= 1'b0;
  endtask
  task rd(input logic [13:0] i, input logic [15:0] e, input logic [1:0] er);
    @(posedge aclk);
    ara <= {i, 2'b00};
    {arv, rq} <= 2'h3;
    do @(negedge aclk); while (!arr);
    @(posedge aclk);
    arv <= 1'b0;
    do @(negedge aclk); while (!rv);
    chk("rdata", {16'h0000, e}, rdd);
    chk("rresp", 32'(er), 32'(rr));
    @(posedge aclk);
    rq <= 1'b0;
  endtask
  task rst(input logic f);
    @(posedge aclk);
    {aresetn, fload} <= {1'b0, f};
    repeat (4) @(posedge aclk);
    {aresetn, fload} <= 2'h2;
  endtask
  // one route element, then look at both pulses
  task bc(input logic [7:0] v, input logic l, input logic ea, input logic ef);
    @(posedge aclk);
    {rval, rvld, rlast} <= {v, 1'b1, l};
    @(posedge aclk);
    {rvld, rlast} <= 2'h0;
    @(negedge aclk);
    chk("apply", 32'(ea), 32'(bap));
    chk("forward", 32'(ef), 32'(bfw));
  endtask
  task gclr;
    @(posedge aclk);
    gq.delete();
  endtask
  task enq1;
    @(posedge aclk);
    sc = 0;
    @(posedge aclk);
    enq <= 4'h1;
    @(posedge aclk);
    enq <= 4'h0;
  endtask
  // wait for the expected grants; stop means no more may follow
  task collect(input int e[$], input bit stop);
    int k;
    k = 0;
    while (gq.size() < e.size() && k < 600)
    begin
      @(posedge aclk);
      k++;
    end
    if (stop) repeat (100) @(posedge aclk);
    chk("grants", e.size(), (stop || gq.size() < e.size()) ? gq.size() : e.size());
    for (int j = 0; j < e.size() && j < gq.size(); j++) chk("drop", e[j], gq[j]);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    for (int i = 0; i < NUM_CFG; i++) rd(CFG_IDX[i], CFG_DEF[i], RESP_OKAY);
    rd(IDX_QCOUNT, 16'h0000, RESP_OKAY);
    rd(14'h0100, 16'h0000, RESP_SLVERR);
    for (int i = 0; i < NUM_CFG; i++) wr(CFG_IDX[i] + PORT_STRIDE, 16'h0A50 + 16'(i), RESP_OKAY);
    for (int i = 0; i < NUM_CFG; i++) rd(CFG_IDX[i] + PORT_STRIDE, 16'h0A50 + 16'(i), RESP_OKAY);
    wr(14'h1FBB, 16'h0077, RESP_OKAY);
    rd(14'h1FBB, 16'h0077, RESP_OKAY);
    rd(CFG_IDX[0], CFG_DEF[0], RESP_OKAY);
    wr(IDX_QCOUNT, 16'h0005, RESP_SLVERR);
    rd(IDX_QCOUNT, 16'h0000, RESP_OKAY);
    wr(CFG_IDX[0], 16'h1234, RESP_OKAY);
    wr(CFG_IDX[0] + PORT_STRIDE, 16'h1234, RESP_OKAY);
    rst(1'b0);
    rd(CFG_IDX[0], 16'h1234, RESP_OKAY);
    rd(CFG_IDX[1] + PORT_STRIDE, 16'h0A51, RESP_OKAY);
    rd(CFG_IDX[0] + PORT_STRIDE, 16'h1234, RESP_OKAY);
    $display("done registers");
  endtask
  task t_bcast;
    for (int v = 233; v <= 254; v++) bc(8'(v), 1'b0, v >= 253 || (v - 233) / 2 == 5, 1'b0);
    bc(8'hFE, 1'b1, 1'b1, 1'b1);
    bc(8'hFD, 1'b1, 1'b1, 1'b0);
    drop <= 7'h00;
    bc(8'hE9, 1'b0, 1'b1, 1'b0);
    bc(8'hEB, 1'b0, 1'b0, 1'b0);
    $display("done broadcast");
  endtask
  task t_msg;
    wr(CFG_IDX[2], 16'h0001, RESP_OKAY);
    wr(CFG_IDX[4], 16'h0002, RESP_OKAY);
    wr(CFG_IDX[5], 16'h0000, RESP_OKAY);
    enq1();
    rd(IDX_QCOUNT, 16'h0001, RESP_OKAY);
    repeat (200) @(posedge aclk);
    chk("sends", 32'd3, sc);
    rd(IDX_QCOUNT, 16'h0000, RESP_OKAY);
    // a timeout of several ticks so the three-cycle ack always wins
    wr(CFG_IDX[2], 16'h0004, RESP_OKAY);
    ack_en <= 1'b1;
    enq1();
    repeat (100) @(posedge aclk);
    chk("sends", 32'd1, sc);
    // one message per burst, then a 16 tick pause holds the second back
    wr(CFG_IDX[5], 16'h0010, RESP_OKAY);
    wr(CFG_IDX[6], 16'h0001, RESP_OKAY);
    enq1();
    enq1();
    repeat (60) @(posedge aclk);
    rd(IDX_QCOUNT, 16'h0001, RESP_OKAY);
    repeat (200) @(posedge aclk);
    rd(IDX_QCOUNT, 16'h0000, RESP_OKAY);
    $display("done messages");
  endtask
  task t_grant;
    gclr();
    wr(CFG_IDX[REG_GRANT], 16'd100, RESP_OKAY);
    collect({0}, 1'b1);
    gclr();
    wr(CFG_IDX[REG_GRANT], 16'd7, RESP_OKAY);
    collect({7}, 1'b1);
    chk("busy", 32'd0, 32'(bsy[0]));
    gclr();
    wr(CFG_IDX[REG_GRANT], 16'd103, RESP_OKAY);
    collect({3, 2, 1, 0}, 1'b1);
    gclr();
    wr(CFG_IDX[REG_GRANT], 16'd302, RESP_OKAY);
    collect({2, 1, 0, 2, 1}, 1'b0);
    wr(CFG_IDX[REG_OPTIONS], 16'h0200, RESP_OKAY);
    repeat (30) @(posedge aclk);
    gclr();
    repeat (200) @(posedge aclk);
    chk("grants", 32'd0, gq.size());
    chk("busy", 32'd1, 32'(bsy[0]));
    wr(CFG_IDX[REG_GRANT], 16'd205, RESP_OKAY);
    gclr();
    wr(CFG_IDX[REG_OPTIONS], 16'h0000, RESP_OKAY);
    collect({5, 5, 5}, 1'b0);
    $display("done grants");
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge aclk);
    {aresetn, fload} <= 2'h2;
    t_regs();
    t_bcast();
    t_msg();
    t_grant();
    wrap_up();
  end
  // hang guard, well beyond the few thousand cycles used
  initial
  begin
    #(20 * 50000);
    num_errors++;
    $display("ERROR watchdog expected end seen hang");
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
